// File: rfmc_top.sv
// rfmc_top: tx and rx mode registers of the contactless unit, with the
// configuration outputs they steer and the transmit serial data path
// assumes: simple strobe bus on clock; external_serial_input is async
//
// Overview of operation
// - tx crc enable set makes every sent data frame carry a crc
// - tx speed codes 000..100 give 106..1696 kbit/s, rest reserved
// - tx rates above 424 use the active 424 kbit/s bit coding
// - modulation invert bit flips the polarity of sent modulation
// - external mix bit merges the external serial input into coder
// - tx frame field: type a, active, passive 212/424, type b
// - tx mode register at 6302h, resets to zero, mixed access
// - rx mode register at 6303h, resets to zero, five fields
// - rx crc enable checks crc and keeps crc bytes out of buffer
// - rx speed field uses the tx speed encoding
`timescale 1ns/1ps
module rfmc_top
  import rfmc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_write,
  input  wire logic        bus_read,
  output logic      [7:0]  bus_rdata,
  input  wire logic        proto_tx_upd,
  input  wire logic        proto_rx_upd,
  input  wire logic [2:0]  proto_speed,
  input  wire logic [1:0]  proto_frame,
  input  wire logic        coder_data,
  input  wire logic        external_serial_input,
  input  wire logic        tx_start,
  output logic             tx_start_ok,
  output logic             tx_mod_out,
  output logic             tx_crc_gen_enable,
  output logic      [2:0]  tx_bit_rate_select,
  output logic             tx_active_coding,
  output logic             modulation_invert,
  output logic             tx_external_mix,
  output logic      [1:0]  tx_frame_format,
  output logic             rx_crc_check_enable,
  output logic             rx_crc_strip,
  output logic      [2:0]  rx_bit_rate_select,
  output logic             rx_quiet_error_option,
  output logic             rx_multi_frame_enable,
  output logic      [1:0]  rx_frame_format
);
  rfmc_reg_if tx_if ();
  rfmc_reg_if rx_if ();
  logic       sig_s1_q;
  logic       sig_s2_q;
  logic       sig_s3_q;
  logic       sig_f_q;
  logic       rate_ok;

  ////////////////////////////////////////////////////////////////////////
  // register stores
  assign tx_if.wr        = bus_write && (bus_addr == TX_MODE_ADDR);
  assign tx_if.wdata     = bus_wdata;
  assign tx_if.upd       = proto_tx_upd;
  assign tx_if.upd_speed = proto_speed;
  assign tx_if.upd_frame = proto_frame;
  assign rx_if.wr        = bus_write && (bus_addr == RX_MODE_ADDR);
  assign rx_if.wdata     = bus_wdata;
  assign rx_if.upd       = proto_rx_upd;
  assign rx_if.upd_speed = proto_speed;
  assign rx_if.upd_frame = proto_frame;

  rfmc_mode_reg u_tx_reg (
    .clock   (clock),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .rif     (tx_if.store)
  );

  rfmc_mode_reg u_rx_reg (
    .clock   (clock),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .rif     (rx_if.store)
  );

  ////////////////////////////////////////////////////////////////////////
  // read port, data in the cycle after the strobe, live values
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bus_rdata <= MODE_RESET;
    end else if (clk_en) begin
      if (bus_read && bus_addr == TX_MODE_ADDR) begin
        bus_rdata <= tx_if.value;
      end else if (bus_read && bus_addr == RX_MODE_ADDR) begin
        bus_rdata <= rx_if.value;
      end else begin
        bus_rdata <= MODE_RESET;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decoded configuration outputs
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_crc_gen_enable     <= 1'b0;
      tx_bit_rate_select    <= SPEED_106;
      tx_active_coding      <= 1'b0;
      modulation_invert     <= 1'b0;
      tx_external_mix       <= 1'b0;
      tx_frame_format       <= FRAME_TYPE_A;
      rx_crc_check_enable   <= 1'b0;
      rx_crc_strip          <= 1'b0;
      rx_bit_rate_select    <= SPEED_106;
      rx_quiet_error_option <= 1'b0;
      rx_multi_frame_enable <= 1'b0;
      rx_frame_format       <= FRAME_TYPE_A;
    end else if (clk_en) begin
      tx_crc_gen_enable     <= tx_if.value[CRC_BIT];
      tx_bit_rate_select    <= tx_if.value[SPEED_HI:SPEED_LO];
      tx_active_coding      <=
        tx_if.value[SPEED_HI:SPEED_LO] > SPEED_424 ||
        tx_if.value[FRAME_HI:FRAME_LO] == FRAME_ACTIVE;
      modulation_invert     <= tx_if.value[OPT_A_BIT];
      tx_external_mix       <= tx_if.value[OPT_B_BIT];
      tx_frame_format       <= tx_if.value[FRAME_HI:FRAME_LO];
      rx_crc_check_enable   <= rx_if.value[CRC_BIT];
      rx_crc_strip          <= rx_if.value[CRC_BIT];
      rx_bit_rate_select    <= rx_if.value[SPEED_HI:SPEED_LO];
      rx_quiet_error_option <= rx_if.value[OPT_A_BIT];
      rx_multi_frame_enable <= rx_if.value[OPT_B_BIT];
      rx_frame_format       <= rx_if.value[FRAME_HI:FRAME_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // external serial input: three stages, change taken when 2 and 3 agree
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sig_s1_q <= 1'b0;
      sig_s2_q <= 1'b0;
      sig_s3_q <= 1'b0;
      sig_f_q  <= 1'b0;
    end else if (clk_en) begin
      sig_s1_q <= external_serial_input;
      sig_s2_q <= sig_s1_q;
      sig_s3_q <= sig_s2_q;
      if (sig_s2_q == sig_s3_q) begin
        sig_f_q <= sig_s3_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit modulation path and start gate
  assign rate_ok = tx_if.value[SPEED_HI:SPEED_LO] <= SPEED_1696;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_mod_out  <= 1'b0;
      tx_start_ok <= 1'b0;
    end else if (clk_en) begin
      // mixing is a logical or of coder and external stream
      tx_mod_out  <= (coder_data | (tx_if.value[OPT_B_BIT] & sig_f_q)) ^
                     tx_if.value[OPT_A_BIT];
      tx_start_ok <= tx_start && rate_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_tx_write_live: assert property (
    @(posedge clock) disable iff (!reset_n)
    clk_en && tx_if.wr && !proto_tx_upd &&
    bus_wdata[SPEED_HI:SPEED_LO] <= SPEED_1696
    ##1 clk_en && !tx_if.wr && !proto_tx_upd && bus_read &&
        bus_addr == TX_MODE_ADDR |=> bus_rdata == $past(bus_wdata, 2))
    else $error("tx mode readback differs from write");
  a_rx_write_live: assert property (
    @(posedge clock) disable iff (!reset_n)
    clk_en && rx_if.wr && !proto_rx_upd &&
    bus_wdata[SPEED_HI:SPEED_LO] <= SPEED_1696
    ##1 clk_en && !rx_if.wr && !proto_rx_upd && bus_read &&
        bus_addr == RX_MODE_ADDR |=> bus_rdata == $past(bus_wdata, 2))
    else $error("rx mode readback differs from write");
  a_crc_follows: assert property (
    @(posedge clock) disable iff (!reset_n)
    clk_en |=> tx_crc_gen_enable == $past(tx_if.value[CRC_BIT]))
    else $error("crc enable output wrong");
  a_rate_out: assert property (
    @(posedge clock) disable iff (!reset_n)
    clk_en |=> tx_bit_rate_select == $past(tx_if.value[SPEED_HI:SPEED_LO]) &&
               tx_bit_rate_select <= SPEED_1696)
    else $error("tx rate output wrong");
  a_high_coding: assert property (
    @(posedge clock) disable iff (!reset_n)
    tx_bit_rate_select > SPEED_424 |-> tx_active_coding)
    else $error("high rate without active coding");
  a_invert_path: assert property (
    @(posedge clock) disable iff (!reset_n)
    clk_en && !tx_if.value[OPT_B_BIT] |=>
      tx_mod_out == ($past(coder_data) ^ $past(tx_if.value[OPT_A_BIT])))
    else $error("modulation polarity wrong");
  a_mix_path: assert property (
    @(posedge clock) disable iff (!reset_n)
    clk_en && tx_if.value[OPT_B_BIT] && !tx_if.value[OPT_A_BIT] && sig_f_q
    |=> tx_mod_out)
    else $error("external stream not mixed");
  a_frame_out: assert property (
    @(posedge clock) disable iff (!reset_n)
    clk_en |=> tx_frame_format == $past(tx_if.value[FRAME_HI:FRAME_LO]))
    else $error("frame format output wrong");
  a_rx_crc_strip: assert property (
    @(posedge clock) disable iff (!reset_n)
    rx_crc_check_enable == rx_crc_strip)
    else $error("crc check and strip disagree");
  a_dyn_update: assert property (
    @(posedge clock) disable iff (!reset_n)
    clk_en && proto_rx_upd && proto_speed <= SPEED_1696 |=>
      rx_if.value[SPEED_HI:SPEED_LO] == $past(proto_speed) &&
      rx_if.value[FRAME_HI:FRAME_LO] == $past(proto_frame))
    else $error("dynamic update not taken");
endmodule

// File: rfmc_pkg.sv
// rfmc_pkg: register map, field layout and codes of the tx/rx mode block
// assumes: 16-bit byte address, 8-bit register data
package rfmc_pkg;
  localparam int          ADDR_W        = 16;
  localparam int          DATA_W        = 8;
  localparam logic [15:0] TX_MODE_ADDR  = 16'h6302;
  localparam logic [15:0] RX_MODE_ADDR  = 16'h6303;
  localparam logic [7:0]  MODE_RESET    = 8'h00;
  localparam int          CRC_BIT       = 7;
  localparam int          SPEED_HI      = 6;
  localparam int          SPEED_LO      = 4;
  localparam int          OPT_A_BIT     = 3;
  localparam int          OPT_B_BIT     = 2;
  localparam int          FRAME_HI      = 1;
  localparam int          FRAME_LO      = 0;
  localparam logic [2:0]  SPEED_106     = 3'h0;
  localparam logic [2:0]  SPEED_212     = 3'h1;
  localparam logic [2:0]  SPEED_424     = 3'h2;
  localparam logic [2:0]  SPEED_848     = 3'h3;
  localparam logic [2:0]  SPEED_1696    = 3'h4;
  localparam logic [1:0]  FRAME_TYPE_A  = 2'h0;
  localparam logic [1:0]  FRAME_ACTIVE  = 2'h1;
  localparam logic [1:0]  FRAME_PASSIVE = 2'h2;
  localparam logic [1:0]  FRAME_TYPE_B  = 2'h3;
endpackage

// File: rfmc_reg_if.sv
// rfmc_reg_if: carries one mode register between the top and its store
// assumes: single clock shared by both ends
`timescale 1ns/1ps
interface rfmc_reg_if;
  logic       wr;
  logic [7:0] wdata;
  logic       upd;
  logic [2:0] upd_speed;
  logic [1:0] upd_frame;
  logic [7:0] value;
  modport store (input wr, input wdata, input upd, input upd_speed,
                 input upd_frame, output value);
  modport ctrl  (output wr, output wdata, output upd, output upd_speed,
                 output upd_frame, input value);
endinterface

// File: rfmc_mode_reg.sv
// rfmc_mode_reg: one 8-bit mode register with software and dynamic fields
// assumes: software write and protocol update come on the same clock
`timescale 1ns/1ps
module rfmc_mode_reg
  import rfmc_pkg::*;
(
  input  wire logic   clock,
  input  wire logic   reset_n,
  input  wire logic   clk_en,
  rfmc_reg_if.store   rif
);
  logic [7:0] value_q;
  logic       speed_ok;

  // reserved rate codes never reach the register
  assign speed_ok = rif.wdata[SPEED_HI:SPEED_LO] <= SPEED_1696;
  assign rif.value = value_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      value_q <= MODE_RESET;
    end else if (clk_en) begin
      if (rif.wr) begin
        value_q[CRC_BIT]   <= rif.wdata[CRC_BIT];
        value_q[OPT_A_BIT] <= rif.wdata[OPT_A_BIT];
        value_q[OPT_B_BIT] <= rif.wdata[OPT_B_BIT];
        value_q[FRAME_HI:FRAME_LO] <= rif.wdata[FRAME_HI:FRAME_LO];
        if (speed_ok) begin
          value_q[SPEED_HI:SPEED_LO] <= rif.wdata[SPEED_HI:SPEED_LO];
        end
      end
      // protocol update wins over a software write in the same cycle on the frame field, and on speed when its code is not reserved
      if (rif.upd) begin
        value_q[FRAME_HI:FRAME_LO] <= rif.upd_frame;
        if (rif.upd_speed <= SPEED_1696) begin
          value_q[SPEED_HI:SPEED_LO] <= rif.upd_speed;
        end
      end
    end
  end

  a_reserved_rate: assert property (
    @(posedge clock) disable iff (!reset_n)
    value_q[SPEED_HI:SPEED_LO] <= SPEED_1696)
    else $error("reserved rate code stored");
endmodule

// File: rfmc_rf_peer.sv
// rfmc_rf_peer: far-side rf peer that drives the external serial input pin
// assumes: bench picks the level; the pin moves off the clock grid
`timescale 1ns/1ps
module rfmc_rf_peer (
  input  wire logic clock,
  input  wire logic level,
  input  wire logic lag,
  output logic      serial_out
);
  initial serial_out = 1'b0;
  // unsynchronised peer: prompt moves early, slow moves late in the cycle
  always @(posedge clock) begin
    serial_out <= #(lag ? 2.7 : 0.9) level;
  end
endmodule

// File: rf_tx_rx_mode_config_tb.sv
// rf_tx_rx_mode_config_tb: self-checking bench of the tx/rx mode registers
// assumes: rfmc_pkg, rfmc_top and rfmc_rf_peer compiled before it
`timescale 1ns/1ps
module rf_tx_rx_mode_config_tb;
  import rfmc_pkg::*;
  logic        clock, reset_n, clk_en, bus_write, bus_read, tx_start;
  logic        proto_tx_upd, proto_rx_upd, coder_data, sig_lvl, peer_lag;
  logic        external_serial_input, tx_start_ok, tx_mod_out, rd_pend;
  logic        tx_crc_gen_enable, tx_active_coding, modulation_invert;
  logic        tx_external_mix, rx_crc_check_enable, rx_crc_strip;
  logic        rx_quiet_error_option, rx_multi_frame_enable;
  logic [2:0]  tx_bit_rate_select, rx_bit_rate_select, proto_speed;
  logic [1:0]  tx_frame_format, rx_frame_format, proto_frame;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata, bus_rdata, tx_e, rx_e, rnd;
  logic [7:0]  exp_q[$];
  int          err_total, checks_done;

  rfmc_top uut (.clock, .reset_n, .clk_en, .bus_addr, .bus_wdata,
    .bus_write, .bus_read, .bus_rdata, .proto_tx_upd, .proto_rx_upd,
    .proto_speed, .proto_frame, .coder_data, .external_serial_input,
    .tx_start, .tx_start_ok, .tx_mod_out, .tx_crc_gen_enable,
    .tx_bit_rate_select, .tx_active_coding, .modulation_invert,
    .tx_external_mix, .tx_frame_format, .rx_crc_check_enable,
    .rx_crc_strip, .rx_bit_rate_select, .rx_quiet_error_option,
    .rx_multi_frame_enable, .rx_frame_format);
  rfmc_rf_peer peer (.clock, .level(sig_lvl), .lag(peer_lag),
    .serial_out(external_serial_input));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_write <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clock);
    bus_write <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clock);
    bus_read <= 1'b1;
    bus_addr <= a;
    exp_q.push_back(e);
    @(posedge clock);
    bus_read <= 1'b0;
  endtask
  // write then read back with no gap between the strobes
  task automatic wrrd(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_write <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clock);
    bus_write <= 1'b0;
    bus_read  <= 1'b1;
    exp_q.push_back(d);
    @(posedge clock);
    bus_read  <= 1'b0;
  endtask
  // protocol update of both registers, optionally racing a software write
  task automatic upd(input logic [2:0] s, input logic [1:0] f, input logic w);
    @(posedge clock);
    proto_tx_upd <= 1'b1;
    proto_rx_upd <= 1'b1;
    proto_speed  <= s;
    proto_frame  <= f;
    bus_write    <= w;
    bus_addr     <= TX_MODE_ADDR;
    bus_wdata    <= 8'h8C;
    @(posedge clock);
    proto_tx_upd <= 1'b0;
    proto_rx_upd <= 1'b0;
    bus_write    <= 1'b0;
  endtask
  task automatic outs(input logic [7:0] tx, input logic [7:0] rx);
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk({tx_crc_gen_enable, tx_bit_rate_select, modulation_invert,
      tx_external_mix, tx_frame_format}, tx);
    chk({rx_crc_check_enable, rx_bit_rate_select, rx_quiet_error_option,
      rx_multi_frame_enable, rx_frame_format}, rx);
    chk({7'h00, tx_active_coding}, {7'h00, tx[6:4] > SPEED_424
      || tx[1:0] == FRAME_ACTIVE});
    chk({7'h00, rx_crc_strip}, {7'h00, rx[7]});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) rd_pend <= bus_read & clk_en;
  always @(negedge clock) begin
    if (rd_pend) begin
      if (exp_q.size() == 0)
        chk(bus_rdata, ~bus_rdata);
      else
        chk(bus_rdata, exp_q.pop_front());
    end
  end
  initial begin
    #40000;
    err_total++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, bus_write, bus_read, tx_start} = '0;
    {proto_tx_upd, proto_rx_upd, coder_data, sig_lvl, peer_lag} = '0;
    {bus_addr, bus_wdata, proto_speed, proto_frame} = '0;
    clk_en = 1'b1;
    err_total = 0;
    checks_done = 0;
    void'($urandom(32'hED0EAC04));
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    rd(TX_MODE_ADDR, MODE_RESET);
    rd(RX_MODE_ADDR, MODE_RESET);
    outs(MODE_RESET, MODE_RESET);
    $display("test reset values done");
    for (int i = 0; i < 20; i++) begin
      rnd = 8'($urandom());
      tx_e = {rnd[7] | (i > 3), 3'(i / 4), rnd[3:2], 2'(i % 4)};
      rx_e = {rnd[6], 3'(i / 4), rnd[1:0], 2'(i % 4)};
      wrrd(TX_MODE_ADDR, tx_e);
      wrrd(RX_MODE_ADDR, rx_e);
      rd(TX_MODE_ADDR, tx_e);
      rd(RX_MODE_ADDR, rx_e);
      outs(tx_e, rx_e);
    end
    $display("test speed and framing codes done");
    for (int c = 5; c < 8; c++) begin
      wr(TX_MODE_ADDR, {1'b1, 3'(c), 4'hF});
      tx_e = {1'b1, tx_e[6:4], 4'hF};
      rd(TX_MODE_ADDR, tx_e);
      wr(RX_MODE_ADDR, {1'b0, 3'(c), 4'h5});
      rx_e = {1'b0, rx_e[6:4], 4'h5};
      rd(RX_MODE_ADDR, rx_e);
    end
    wr(16'h6304, 8'hAA);
    rd(16'h6304, 8'h00);
    rd(16'h6301, 8'h00);
    @(posedge clock);
    clk_en <= 1'b0;
    wr(TX_MODE_ADDR, 8'h00);
    @(posedge clock);
    clk_en <= 1'b1;
    rd(TX_MODE_ADDR, tx_e);
    $display("test reserved and unmapped done");
    upd(SPEED_848, FRAME_PASSIVE, 1'b1);
    tx_e = {1'b1, SPEED_848, 2'b11, FRAME_PASSIVE};
    rx_e = {rx_e[7], SPEED_848, rx_e[3:2], FRAME_PASSIVE};
    rd(TX_MODE_ADDR, tx_e);
    rd(RX_MODE_ADDR, rx_e);
    upd(3'h7, FRAME_TYPE_B, 1'b0);
    tx_e = {tx_e[7:2], FRAME_TYPE_B};
    rx_e = {rx_e[7:2], FRAME_TYPE_B};
    rd(TX_MODE_ADDR, tx_e);
    outs(tx_e, rx_e);
    $display("test protocol update done");
    for (int i = 0; i < 16; i++) begin
      wr(TX_MODE_ADDR,
         {1'b1, SPEED_106, i[3], i[2], FRAME_TYPE_A});
      coder_data <= i[1];
      sig_lvl    <= i[0];
      peer_lag   <= i[0];
      repeat (10) @(posedge clock);
      @(negedge clock);
      chk({7'h00, tx_mod_out},
          {7'h00, (i[1] | (i[2] & i[0])) ^ i[3]});
    end
    @(posedge clock);
    tx_start <= 1'b1;
    @(posedge clock);
    tx_start <= 1'b0;
    @(negedge clock);
    chk({7'h00, tx_start_ok}, 8'h01);
    @(negedge clock);
    chk({7'h00, tx_start_ok}, 8'h00);
    $display("test serial path done");
    repeat (3) @(posedge clock);
    close_out();
  end
endmodule
